/* File: design/vpe_top.sv */
// Purpose: dma request generation and merged interrupt pulse for a video port
// Assumes: fifo levels, access strobes and flag sets arrive synchronous to core_clk_i
// Notes:   index 0 luma, 1 blue chroma, 2 red chroma; channel a capture, b display
`timescale 1ns/10ps
`include "vpe_defs.svh"

// Functional notes
// [RULE_01] soft reset halts requests, clears display
// [RULE_02] soft reset bit self clears when done
// [RULE_03] bus writes still acknowledged during reset
// [RULE_04] enable locks other display control bits
// [RULE_05] blank bit gates display requests
// [RULE_06] twelve flags can raise interrupt
// [RULE_07] pulse only on zero to nonzero; the code also pulses when a clear leaves enabled flags pending
// [RULE_08] per source and global masks
// [RULE_09] write one clears, rearms pulse
// [RULE_10] isr reads, services, clears flags
// [RULE_11] six dedicated dma request outputs
// [RULE_12] capture request on threshold, one pending
// [RULE_13] second capture request above twice threshold
// [RULE_14] outgoing counter counts serviced double-words
// [RULE_15] three fifos tracked independently
// [RULE_16] chroma capture threshold rounds half up
// [RULE_17] field event counter selects threshold
// [RULE_18] display request on free space
// [RULE_19] extra display request at twice space
// [RULE_20] incoming counter counts written double-words
// [RULE_21] display event counter limits field requests
// [RULE_22] transfers are whole double-words only
// [RULE_23] requests and interrupt are pulses
module vpe_top (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_n_i,
  // display control
  input  wire logic                 ctl_wr_i,
  input  wire logic                 ctl_enable_i,
  input  wire logic                 ctl_blank_i,
  input  wire logic                 ctl_soft_reset_i,
  input  wire logic                 ctl_other_i,
  input  wire logic                 channel_pixel_clock_tick_i,
  output logic                      display_enable_bit_o,
  output logic                      display_blank_bit_o,
  output logic                      channel_soft_reset_o,
  output logic                      display_other_o,
  output logic                      display_fifo_flush_o,
  output logic                      display_outputs_drive_o,
  // capture fifos
  input  wire logic                 cap_enable_i,
  input  wire logic                 cap_field_start_i,
  input  vpe_pkg::vpe_thr_t         field_one_threshold_i,
  input  vpe_pkg::vpe_thr_t         field_two_threshold_i,
  input  vpe_pkg::vpe_evt_t         field_one_cap_events_i,
  input  vpe_pkg::vpe_lvl_t         cap_level_i [3],
  input  wire logic [2:0]           cap_read_i,
  // display fifos
  input  vpe_pkg::vpe_thr_t         display_threshold_i,
  input  vpe_pkg::vpe_evt_t         field_one_display_events_i,
  input  vpe_pkg::vpe_evt_t         field_two_display_events_i,
  input  wire logic                 disp_field_start_i,
  input  wire logic                 disp_field_two_i,
  input  vpe_pkg::vpe_lvl_t         disp_free_i [3],
  input  wire logic [2:0]           disp_write_i,
  output logic                      disp_write_ack_o,
  // dma requests
  output logic                      luma_request_a_o,
  output logic                      blue_chroma_request_a_o,
  output logic                      red_chroma_request_a_o,
  output logic                      luma_request_b_o,
  output logic                      blue_chroma_request_b_o,
  output logic                      red_chroma_request_b_o,
  // interrupts
  input  wire logic [11:0]          flag_set_i,
  input  wire logic [11:0]          status_clear_i,
  input  wire logic [11:0]          interrupt_enable_reg_i,
  input  wire logic                 global_interrupt_enable_i,
  output logic [11:0]               interrupt_status_reg_o,
  output logic                      vp_interrupt_o
);
  import vpe_pkg::*;

  typedef struct packed {
    logic                     en;
    logic                     blank;
    logic                     srst;
    logic                     other;
    logic [2:0]               rst_cnt;
    logic                     flush;
    logic                     ack;
    vpe_req_st_t [2:0]        cst;
    vpe_thr_t [2:0]           ccnt;
    vpe_evt_t [2:0]           cevt;
    logic [2:0]               cf2;
    vpe_req_st_t [2:0]        dst;
    vpe_thr_t [2:0]           dcnt;
    vpe_evt_t [2:0]           devt;
    logic [5:0]               req;
    logic [11:0]              stat;
    logic                     armed;
    logic                     irq;
  } vpe_state_t;

  vpe_state_t st_reg, st_next;

  function automatic vpe_lvl_t ext(input vpe_thr_t v);
    ext = vpe_lvl_t'(v);
  endfunction

  always_comb begin
    vpe_thr_t ct1, ct2, cthr, nthr, dthr;
    logic [11:0] pend;
    logic hit, go_c, go_d, rearm;
    st_next = st_reg;
    ct1 = '0; ct2 = '0; cthr = '0; nthr = '0; dthr = '0;
    pend = '0; hit = 1'b0; go_c = 1'b0; go_d = 1'b0;
    rearm = 1'b0;
    st_next.req = 6'h00;
    st_next.irq = 1'b0;
    st_next.flush = 1'b0;
    // [RULE_03] always acknowledged
    // acked even in reset so the dma controller never stalls
    st_next.ack = |disp_write_i;
    // display control: enable locks other bits
    if (ctl_wr_i) begin
      st_next.en = ctl_enable_i;
      st_next.blank = ctl_blank_i;
      if (ctl_soft_reset_i)
        st_next.srst = 1'b1;
      // [RULE_04] other bits locked
      if (!st_reg.en)
        st_next.other = ctl_other_i;
    end
    // [RULE_01] reset display channel
    if (st_reg.srst) begin
      st_next.en = 1'b0;
      st_next.blank = 1'b1;
      st_next.other = 1'b0;
      st_next.flush = 1'b1;
      for (int i = 0; i < 3; i++) begin
        st_next.dst[i] = VPE_IDLE;
        st_next.dcnt[i] = '0;
        st_next.devt[i] = '0;
      end
      // [RULE_02] self clear needs pixel clock
      if (channel_pixel_clock_tick_i) begin
        if (st_reg.rst_cnt == 3'(`VPE_RST_CYC - 1)) begin
          st_next.srst = 1'b0;
          st_next.rst_cnt = '0;
        end else
          st_next.rst_cnt = st_reg.rst_cnt + 3'h1;
      end
    end
    // [RULE_15] capture fifos tracked separately
    for (int i = 0; i < 3; i++) begin
      // [RULE_16] chroma threshold rounds up
      if (i == 0) begin
        ct1 = field_one_threshold_i;
        ct2 = field_two_threshold_i;
      end else begin
        ct1 = vpe_thr_t'((field_one_threshold_i >> 1) + field_one_threshold_i[0]);
        ct2 = vpe_thr_t'((field_two_threshold_i >> 1) + field_two_threshold_i[0]);
      end
      // [RULE_17] field counter picks threshold
      cthr = st_reg.cf2[i] ? ct2 : ct1;
      nthr = (st_reg.cevt[i] == vpe_evt_t'(1) && !st_reg.cf2[i]) ? ct2 : cthr;
      if (cap_field_start_i) begin
        st_next.cf2[i] = 1'b0;
        st_next.cevt[i] = field_one_cap_events_i;
      end
      if (!cap_enable_i) begin
        st_next.cst[i] = VPE_IDLE;
      end else begin
        unique case (st_reg.cst[i])
          // [RULE_12] request on threshold crossing
          VPE_IDLE: go_c = cap_level_i[i] >= ext(cthr) && cthr != '0;
          VPE_PEND: go_c = 1'b0;
          // [RULE_13] one extra request outstanding
          VPE_SERV: go_c = cap_level_i[i] > (ext(cthr) + ext(nthr));
          VPE_SERV_PEND: go_c = 1'b0;
        endcase
        if (go_c) begin
          st_next.req[i] = 1'b1;
          st_next.cst[i] = (st_reg.cst[i] == VPE_IDLE) ? VPE_PEND : VPE_SERV_PEND;
          if (st_reg.cevt[i] > vpe_evt_t'(1))
            st_next.cevt[i] = st_reg.cevt[i] - vpe_evt_t'(1);
          else if (!st_reg.cf2[i])
            st_next.cf2[i] = 1'b1;
        end
        // [RULE_14] outgoing double-word counter
        // [RULE_22] one read strobe per double-word
        if (cap_read_i[i]) begin
          if (st_reg.cst[i] == VPE_PEND) begin
            st_next.ccnt[i] = cthr - vpe_thr_t'(1);
            // a one double-word service ends on its first read
            if (cthr == vpe_thr_t'(1))
              st_next.cst[i] = VPE_IDLE;
            else
              st_next.cst[i] = VPE_SERV;
          end else if (st_reg.ccnt[i] != '0) begin
            st_next.ccnt[i] = st_reg.ccnt[i] - vpe_thr_t'(1);
            // a request raised in the closing cycle must stay pending
            if (st_reg.ccnt[i] == vpe_thr_t'(1))
              st_next.cst[i] = (st_reg.cst[i] == VPE_SERV_PEND || go_c) ? VPE_PEND : VPE_IDLE;
          end
        end
      end
    end
    // display fifos
    for (int i = 0; i < 3; i++) begin
      // chroma display threshold truncates; odd values are the user's problem
      if (i == 0)
        dthr = display_threshold_i;
      else
        dthr = display_threshold_i >> 1;
      // [RULE_21] event count per field
      if (disp_field_start_i)
        st_next.devt[i] = disp_field_two_i ? field_two_display_events_i
                                           : field_one_display_events_i;
      // [RULE_05] blank gates requests
      hit = st_reg.en && !st_reg.blank && !st_reg.srst && st_reg.devt[i] != '0
            && dthr != '0;
      unique case (st_reg.dst[i])
        // [RULE_18] request on free space
        VPE_IDLE: go_d = hit && disp_free_i[i] >= ext(dthr);
        VPE_PEND: go_d = 1'b0;
        // [RULE_19] extra at twice space
        VPE_SERV: go_d = hit && disp_free_i[i] >= (ext(dthr) << 1);
        VPE_SERV_PEND: go_d = 1'b0;
      endcase
      if (go_d) begin
        st_next.req[3+i] = 1'b1;
        st_next.dst[i] = (st_reg.dst[i] == VPE_IDLE) ? VPE_PEND : VPE_SERV_PEND;
        if (!disp_field_start_i)
          st_next.devt[i] = st_reg.devt[i] - vpe_evt_t'(1);
      end
      // [RULE_20] incoming double-word counter
      // [RULE_22] one write strobe per double-word
      if (disp_write_i[i] && !st_reg.srst) begin
        if (st_reg.dst[i] == VPE_PEND) begin
          st_next.dcnt[i] = dthr - vpe_thr_t'(1);
          // a one double-word service ends on its first write
          if (dthr == vpe_thr_t'(1))
            st_next.dst[i] = VPE_IDLE;
          else
            st_next.dst[i] = VPE_SERV;
        end else if (st_reg.dcnt[i] != '0) begin
          st_next.dcnt[i] = st_reg.dcnt[i] - vpe_thr_t'(1);
          // a request raised in the closing cycle must stay pending
          if (st_reg.dcnt[i] == vpe_thr_t'(1))
            st_next.dst[i] = (st_reg.dst[i] == VPE_SERV_PEND || go_d) ? VPE_PEND : VPE_IDLE;
        end
      end
    end
    // [RULE_06] sticky flags, set wins over clear
    // [RULE_09] write one clears
    st_next.stat = (st_reg.stat & ~status_clear_i) | flag_set_i;
    // [RULE_08] individual and global masks
    pend = st_next.stat & interrupt_enable_reg_i;
    // clearing any set flag rearms the pulse
    rearm = st_reg.armed || (|(status_clear_i & st_reg.stat));
    st_next.armed = rearm;
    // [RULE_07] pulse on none to some
    if (global_interrupt_enable_i && (|pend) && rearm) begin
      st_next.irq = 1'b1;
      st_next.armed = 1'b0;
    end else if (!global_interrupt_enable_i || !(|pend)) begin
      // nothing visible pending, so the next flag may pulse
      st_next.armed = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
      st_reg.blank <= 1'b1;
      st_reg.armed <= 1'b1;
    end else
      st_reg <= st_next;
  end

  // outputs straight from flops
  assign display_enable_bit_o = st_reg.en;
  assign display_blank_bit_o = st_reg.blank;
  assign channel_soft_reset_o = st_reg.srst;
  assign display_other_o = st_reg.other;
  assign display_fifo_flush_o = st_reg.flush;
  assign display_outputs_drive_o = st_reg.en;
  assign disp_write_ack_o = st_reg.ack;
  // [RULE_11] six request lines
  // [RULE_23] one cycle pulses
  assign luma_request_a_o = st_reg.req[0];
  assign blue_chroma_request_a_o = st_reg.req[1];
  assign red_chroma_request_a_o = st_reg.req[2];
  assign luma_request_b_o = st_reg.req[3];
  assign blue_chroma_request_b_o = st_reg.req[4];
  assign red_chroma_request_b_o = st_reg.req[5];
  assign interrupt_status_reg_o = st_reg.stat;
  assign vp_interrupt_o = st_reg.irq;
endmodule

/* File: design/vpe_defs.svh */
// Purpose: constants for the video port event and interrupt block
// Assumes: thresholds and counts in double-words
// Notes:   widths fixed
`ifndef VPE_DEFS_SVH
`define VPE_DEFS_SVH
`define VPE_THR_W      12
`define VPE_EVT_W      12
`define VPE_NFLAG      12
`define VPE_RST_CYC    4
`define VPE_LVL_W      14
`endif

/* File: design/vpe_pkg.sv */
// Purpose: types for the video port event and interrupt block
// Assumes: defs header included first
// Notes:   one request tracker state per fifo
`include "vpe_defs.svh"
package vpe_pkg;
  typedef enum logic [1:0] {VPE_IDLE, VPE_PEND, VPE_SERV, VPE_SERV_PEND} vpe_req_st_t;
  typedef logic [`VPE_THR_W-1:0] vpe_thr_t;
  typedef logic [`VPE_LVL_W-1:0] vpe_lvl_t;
  typedef logic [`VPE_EVT_W-1:0] vpe_evt_t;
endpackage

/* File: tb/vpe_top_sva.sv */
// Purpose: port assertions for vpe_top
// Assumes: one clock domain, sync active-low reset
// Notes:   flag sets are recorded in status even when masked
`timescale 1ns/10ps
module vpe_top_sva (
  input wire logic        core_clk_i, reset_n_i, display_blank_bit_o, channel_soft_reset_o,
  input wire logic        luma_request_a_o, blue_chroma_request_a_o, red_chroma_request_a_o,
  input wire logic        luma_request_b_o, blue_chroma_request_b_o, red_chroma_request_b_o,
  input wire logic [2:0]  disp_write_i,
  input wire logic        disp_write_ack_o, vp_interrupt_o,
  input wire logic [11:0] flag_set_i, status_clear_i, interrupt_status_reg_o
);
  wire [5:0]  req = {red_chroma_request_b_o, blue_chroma_request_b_o, luma_request_b_o,
                     red_chroma_request_a_o, blue_chroma_request_a_o, luma_request_a_o};
  // a clear in the same cycle as a set loses
  wire [11:0] clr = status_clear_i & ~flag_set_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_REQ_PULSE: assert property (|req |=> (req & $past(req)) == 6'h00)
    else $error("request longer than one cycle");
  AST_RST_QUIET: assert property (channel_soft_reset_o && $past(channel_soft_reset_o)
    |-> req[5:3] == 3'h0) else $error("display request during soft reset");
  AST_BLANK_QUIET: assert property (display_blank_bit_o && $past(display_blank_bit_o)
    |-> req[5:3] == 3'h0) else $error("display request while blanked");
  AST_INT_ONCE: assert property (vp_interrupt_o |=> !vp_interrupt_o)
    else $error("interrupt longer than one cycle");
  AST_INT_SRC: assert property (vp_interrupt_o |-> interrupt_status_reg_o != 12'h000)
    else $error("interrupt with no flag set");
  AST_SET: assert property (flag_set_i != 12'h000
    |=> (interrupt_status_reg_o & $past(flag_set_i)) == $past(flag_set_i))
    else $error("flag not recorded");
  AST_CLR: assert property (clr != 12'h000
    |=> (interrupt_status_reg_o & $past(clr)) == 12'h000) else $error("flag not cleared");
  AST_ACK: assert property (disp_write_i != 3'h0 |=> disp_write_ack_o)
    else $error("write not acknowledged");
endmodule
bind vpe_top vpe_top_sva vpe_top_sva_inst (.*);

/* File: tb/vpe_dma_model.sv */
// Purpose: far-side dma model, one service of thr_i double-words per request
// Assumes: index 0..2 capture y,cb,cr and 3..5 display y,cb,cr
// Notes:   lat_i delays each service start, modelling a busy controller
`timescale 1ns/10ps
module vpe_dma_model (
  input  wire logic       clk_i,
  input  wire logic [5:0] req_i,
  input  wire logic [7:0] thr_i [6],
  input  wire logic [3:0] lat_i,
  output logic      [2:0] cap_read_o,
  output logic      [2:0] disp_write_o
);
  int pend [6] = '{default:0};
  int left [6] = '{default:0};
  int hold [6] = '{default:0};
  logic [5:0] strobe = 6'h00;
  assign {disp_write_o, cap_read_o} = strobe;
  always @(posedge clk_i) begin
    for (int k = 0; k < 6; k++) begin
      pend[k] += int'(req_i[k]);
      strobe[k] <= 1'b0;
      if (left[k] > 0 && hold[k] > 0) begin
        hold[k]--;
      end else if (left[k] > 0) begin
        strobe[k] <= 1'b1;
        left[k]--;
      end else if (pend[k] > 0) begin
        pend[k]--;
        left[k] = thr_i[k];
        hold[k] = lat_i;
      end
    end
  end
endmodule

/* File: tb/tb_vpe_top.sv */
// Purpose: self-checking bench for vpe_top
// Assumes: thresholds in double-words, dma model on the far side
// Notes:   request and interrupt pulses are counted on every rising edge
`timescale 1ns/10ps
module tb_vpe_top;
  import vpe_pkg::*;
  logic clk = 0, rst_n = 0, c_wr = 0, c_en = 0, c_bl = 0, c_sr = 0, c_ot = 0, pix = 0;
  logic cap_en = 0, cap_fs = 0, d_fs = 0, gie = 0, en_o, bl_o, sr_o, ot_o, irq;
  logic ack, flush, drv;
  logic [11:0] fset = 0, fclr = 0, ien = 0, stat;
  logic [5:0]  req;
  logic [2:0]  rd, wr, dwr = 0;
  logic [3:0]  lat = 1;
  logic [7:0]  mthr [6] = '{8'h05, 8'h03, 8'h03, 8'h04, 8'h02, 8'h02};
  vpe_thr_t    thr = 0;
  vpe_evt_t    evt = 0;
  vpe_lvl_t    clvl [3] = '{default:0};
  vpe_lvl_t    dfree [3] = '{default:0};
  int failures = 0, comparisons = 0, icnt = 0, rcnt [6] = '{default:0};
  vpe_top vpe_top_inst (.core_clk_i(clk), .reset_n_i(rst_n), .ctl_wr_i(c_wr),
    .ctl_enable_i(c_en), .ctl_blank_i(c_bl), .ctl_soft_reset_i(c_sr), .ctl_other_i(c_ot),
    .channel_pixel_clock_tick_i(pix), .display_enable_bit_o(en_o), .display_blank_bit_o(bl_o),
    .channel_soft_reset_o(sr_o), .display_other_o(ot_o), .display_fifo_flush_o(flush),
    .display_outputs_drive_o(drv), .cap_enable_i(cap_en), .cap_field_start_i(cap_fs),
    .field_one_threshold_i(thr), .field_two_threshold_i(thr), .field_one_cap_events_i(evt),
    .cap_level_i(clvl), .cap_read_i(rd), .display_threshold_i(thr),
    .field_one_display_events_i(12'h001), .field_two_display_events_i(12'h001),
    .disp_field_start_i(d_fs), .disp_field_two_i(1'b0), .disp_free_i(dfree),
    .disp_write_i(wr | dwr), .disp_write_ack_o(ack), .luma_request_a_o(req[0]),
    .blue_chroma_request_a_o(req[1]), .red_chroma_request_a_o(req[2]),
    .luma_request_b_o(req[3]), .blue_chroma_request_b_o(req[4]), .red_chroma_request_b_o(req[5]),
    .flag_set_i(fset), .status_clear_i(fclr), .interrupt_enable_reg_i(ien),
    .global_interrupt_enable_i(gie), .interrupt_status_reg_o(stat), .vp_interrupt_o(irq));
  vpe_dma_model vpe_dma_model_inst (.clk_i(clk), .req_i(req), .thr_i(mthr), .lat_i(lat),
    .cap_read_o(rd), .disp_write_o(wr));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    for (int k = 0; k < 6; k++) if (req[k]) rcnt[k]++;
    if (irq) icnt++;
  end
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ctl(logic en, logic bl, logic sr, logic ot);
    @(negedge clk);
    {c_wr, c_en, c_bl, c_sr, c_ot} = {1'b1, en, bl, sr, ot};
    @(negedge clk);
    {c_wr, c_sr} = 2'b00;
  endtask
  task automatic flag(logic [11:0] s, logic [11:0] c);
    @(negedge clk);
    {fset, fclr} = {s, c};
    @(negedge clk);
    {fset, fclr} = 24'h000000;
    cyc(2);
  endtask
  task automatic t_irq();
    {ien, gie} = 13'h1fff;
    for (int k = 0; k < 12; k++) begin
      icnt = 0;
      flag(12'h001 << k, 12'h000);
      chk("irq pulse", 16'h0001, 16'(icnt));
      flag(12'h000, 12'h001 << k);
      chk("status", 16'h0000, {4'h0, stat});
    end
    icnt = 0;
    flag(12'h001, 12'h000);
    flag(12'h002, 12'h000);
    chk("irq stacked", 16'h0001, 16'(icnt));
    flag(12'h000, 12'h001);
    chk("irq rearm", 16'h0002, 16'(icnt));
    flag(12'h000, 12'h002);
    ien = 12'hffe;
    flag(12'h001, 12'h000);
    flag(12'h000, 12'h001);
    gie = 1'b0;
    flag(12'h004, 12'h000);
    flag(12'h000, 12'h004);
    chk("irq masked", 16'h0002, 16'(icnt));
    $display("interrupt test done");
  endtask
  task automatic t_cap();
    {thr, evt, cap_en, lat, cap_fs} = {12'h005, 12'h064, 1'b1, 4'hf, 1'b1};
    @(negedge clk);
    cap_fs = 1'b0;
    clvl = '{14'h0005, 14'h0003, 14'h0002};
    rcnt = '{default:0};
    cyc(12);
    chk("cap y req", 16'h0001, 16'(rcnt[0]));
    chk("cap cb req", 16'h0001, 16'(rcnt[1]));
    chk("cap cr req", 16'h0000, 16'(rcnt[2]));
    cyc(20);
    chk("cap y after service", 16'h0002, 16'(rcnt[0]));
    {clvl[0], clvl[1], clvl[2], cap_en, lat} = {42'h0, 1'b0, 4'h1};
    cyc(40);
    $display("capture test done");
  endtask
  task automatic t_disp();
    {thr, d_fs} = {12'h004, 1'b1};
    dfree = '{14'h0064, 14'h0064, 14'h0001};
    ctl(1'b1, 1'b1, 1'b0, 1'b0);
    d_fs = 1'b0;
    rcnt = '{default:0};
    cyc(10);
    chk("blanked reqs", 16'h0000, 16'(rcnt[3] + rcnt[4]));
    ctl(1'b1, 1'b0, 1'b0, 1'b0);
    chk("outputs driven", 16'h0001, {15'h0, drv});
    cyc(40);
    chk("disp y req", 16'h0001, 16'(rcnt[3]));
    chk("disp cb req", 16'h0001, 16'(rcnt[4]));
    chk("disp cr req", 16'h0000, 16'(rcnt[5]));
    ctl(1'b1, 1'b0, 1'b0, 1'b1);
    chk("other locked", 16'h0000, {15'h0, ot_o});
    $display("display test done");
  endtask
  task automatic t_srst();
    ctl(1'b1, 1'b0, 1'b1, 1'b0);
    cyc(5);
    chk("reset waits", 16'h0001, {15'h0, sr_o});
    chk("fifo flush", 16'h0001, {15'h0, flush});
    {pix, dwr} = 4'h9;
    @(negedge clk);
    chk("write ack in reset", 16'h0001, {15'h0, ack});
    for (int i = 0; i < 20 && sr_o; i++) @(negedge clk);
    {pix, dwr} = 4'h0;
    chk("reset done", 16'h0000, {15'h0, sr_o});
    chk("enable cleared", 16'h0000, {15'h0, en_o});
    chk("blank default", 16'h0001, {15'h0, bl_o});
    chk("outputs released", 16'h0000, {15'h0, drv});
    $display("soft reset test done");
  endtask
  initial begin
    cyc(4);
    rst_n = 1'b1;
    cyc(1);
    chk("blank at reset", 16'h0001, {15'h0, bl_o});
    chk("status at reset", 16'h0000, {4'h0, stat});
    $display("reset test done");
    t_irq();
    t_cap();
    t_disp();
    t_srst();
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
endmodule
